// *** verilog/adcc_defs.svh ***
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
// Byte addresses on the register bus
`define ADCC_OFF_STATUS_CONTROL 12'h03c
`define ADCC_OFF_RESULT 12'h040
`define ADCC_OFF_CLOCK_CONFIG 12'h044
`define ADCC_OFF_IRQ_STATUS 12'h048
`define ADCC_OFF_IRQ_MASK 12'h04c
// Status/control field positions
`define ADCC_BIT_DONE 7
`define ADCC_BIT_IRQ_EN 6
`define ADCC_BIT_CONT 5
`define ADCC_CH_LSB 0
`define ADCC_CH_W 5
// Clock config field positions
`define ADCC_DIV_LSB 5
`define ADCC_DIV_W 3
`define ADCC_BIT_SRC 4
// Reset values
`define ADCC_CH_RESET 5'h1f
`define ADCC_DIV_RESET 3'h0
// Channel codes
`define ADCC_CH_PIN_MAX 5'h03
`define ADCC_CH_HIGH_REF 5'h1d
`define ADCC_CH_GND_REF 5'h1e
`define ADCC_CH_OFF 5'h1f
// Converter clock cycles per conversion
`define ADCC_CONV_CYCLES 5'd17
// Event status bits
`define ADCC_EV_DONE 0
`define ADCC_EV_OVERRUN 1
`define ADCC_EV_W 2
`endif

// *** verilog/adcc_pkg.sv ***
`default_nettype none
package adcc_pkg;
  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_START,
    ADCC_WAIT
  } adcc_state_t;
  typedef enum logic [2:0] {
    ADCC_SEL_PIN,
    ADCC_SEL_HIGH_REF,
    ADCC_SEL_GND_REF,
    ADCC_SEL_UNUSED,
    ADCC_SEL_OFF
  } adcc_input_t;
endpackage : adcc_pkg
`default_nettype wire

// *** verilog/adcc_top.sv ***
`include "adcc_defs.svh"
`default_nettype none
module adcc_top
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_OSC_CLK_EN,
  input wire logic I_CORE_DONE,
  input wire logic [DATA_W-1:0] I_CORE_RESULT,
  output logic O_CORE_START,
  output logic [4:0] O_CORE_CHANNEL,
  output logic O_CORE_POWER_ON,
  output logic [2:0] O_CORE_INPUT,
  output logic O_CONV_CLK_EN,
  output logic O_IRQ,
  output logic O_CPU_IRQ,
  output logic O_DMA_REQ
);
  // Result path is fixed at 8 bits; the address must be at least 8 bits wide
  if (DATA_W != 8) begin : g_bad_data_w
    $error("adcc_top: result width must be 8");
  end
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("adcc_top: address too narrow");
  end

  logic done_flag_r;
  logic irq_en_r;
  logic cont_r;
  logic [4:0] chan_r;
  logic [2:0] div_sel_r;
  logic src_bus_r;
  logic [7:0] result_r;
  logic conv_irq_r;
  logic [`ADCC_EV_W-1:0] ev_status_r;
  logic [`ADCC_EV_W-1:0] ev_mask_r;
  logic [3:0] presc_r;
  logic [4:0] conv_cnt_r;
  logic unread_r;
  adcc_state_t state_r;

  logic wr_acc;
  logic rd_acc;
  logic wr_ctl;
  logic rd_res;
  logic rd_evs;
  logic addr_ok;
  logic in_clk_en;
  logic conv_tick;
  logic conv_done;
  logic powered;
  logic sel_ctl;
  logic sel_res;
  logic sel_clk;
  logic sel_evs;
  logic sel_msk;
  logic wr_clk;
  logic wr_msk;
  logic [`ADCC_EV_W-1:0] ev_set;

  // Zero-wait slave: every access completes in its first access cycle
  assign sel_ctl = (I_PADDR == `ADCC_OFF_STATUS_CONTROL);
  assign sel_res = (I_PADDR == `ADCC_OFF_RESULT);
  assign sel_clk = (I_PADDR == `ADCC_OFF_CLOCK_CONFIG);
  assign sel_evs = (I_PADDR == `ADCC_OFF_IRQ_STATUS);
  assign sel_msk = (I_PADDR == `ADCC_OFF_IRQ_MASK);
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_acc = I_PSEL && I_PENABLE && !I_PWRITE;
  assign addr_ok = sel_ctl || sel_res || sel_clk || sel_evs || sel_msk;
  // Lane 0 carries every register; other lanes alone write nothing
  assign wr_ctl = wr_acc && I_PSTRB[0] && sel_ctl;
  assign wr_clk = wr_acc && I_PSTRB[0] && sel_clk;
  assign wr_msk = wr_acc && I_PSTRB[0] && sel_msk;
  assign rd_res = rd_acc && sel_res;
  assign rd_evs = rd_acc && sel_evs;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok;

  assign powered = (chan_r != `ADCC_CH_OFF);
  assign O_CORE_POWER_ON = powered;
  assign O_CORE_CHANNEL = chan_r;

  // Input decode for the analog mux
  always_comb begin
    if (chan_r <= `ADCC_CH_PIN_MAX) begin
      O_CORE_INPUT = ADCC_SEL_PIN;
    end else if (chan_r == `ADCC_CH_HIGH_REF) begin
      O_CORE_INPUT = ADCC_SEL_HIGH_REF;
    end else if (chan_r == `ADCC_CH_GND_REF) begin
      O_CORE_INPUT = ADCC_SEL_GND_REF;
    end else if (chan_r == `ADCC_CH_OFF) begin
      O_CORE_INPUT = ADCC_SEL_OFF;
    end else begin
      O_CORE_INPUT = ADCC_SEL_UNUSED;
    end
  end

  // Oscillator clock arrives as an enable; the bus clock is every cycle
  assign in_clk_en = src_bus_r ? 1'b1 : I_OSC_CLK_EN;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      presc_r <= 4'h0;
    end else if (in_clk_en) begin
      presc_r <= presc_r + 4'h1;
    end
  end

  // Tick when all divider bits below the chosen ratio are ones
  always_comb begin
    case (div_sel_r)
      3'h0: begin
        conv_tick = in_clk_en;
      end
      3'h1: begin
        conv_tick = in_clk_en && presc_r[0];
      end
      3'h2: begin
        conv_tick = in_clk_en && (&presc_r[1:0]);
      end
      3'h3: begin
        conv_tick = in_clk_en && (&presc_r[2:0]);
      end
      default: begin
        conv_tick = in_clk_en && (&presc_r);
      end
    endcase
  end
  assign O_CONV_CLK_EN = conv_tick;

  // Sequencer; start is a one-cycle pulse, done comes from the core
  assign conv_done = (state_r == ADCC_WAIT) && I_CORE_DONE;
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      state_r <= ADCC_IDLE;
    end else begin
      case (state_r)
        ADCC_IDLE: begin
          if (wr_ctl && (I_PWDATA[4:0] != `ADCC_CH_OFF)) begin
            state_r <= ADCC_START;
          end
        end
        ADCC_START: begin
          if (!powered) begin
            state_r <= ADCC_IDLE;
          end else if (conv_tick) begin
            state_r <= ADCC_WAIT;
          end
        end
        ADCC_WAIT: begin
          if (wr_ctl) begin
            state_r <= (I_PWDATA[4:0] != `ADCC_CH_OFF) ? ADCC_START : ADCC_IDLE;
          end else if (!powered) begin
            state_r <= ADCC_IDLE;
          end else if (conv_done) begin
            state_r <= cont_r ? ADCC_START : ADCC_IDLE;
          end
        end
        default: state_r <= ADCC_IDLE;
      endcase
    end
  end
  assign O_CORE_START = (state_r == ADCC_START) && conv_tick && powered;

  // Converter clock count during the wait state, saturating at ADCC_CONV_CYCLES; no register reads it
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST || state_r != ADCC_WAIT) begin
      conv_cnt_r <= 5'h0;
    end else if (conv_tick && conv_cnt_r != `ADCC_CONV_CYCLES) begin
      conv_cnt_r <= conv_cnt_r + 5'h1;
    end
  end

  // Control fields; the done flag bit is not writable
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      irq_en_r <= 1'b0;
    end else if (wr_ctl) begin
      irq_en_r <= I_PWDATA[`ADCC_BIT_IRQ_EN];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      cont_r <= 1'b0;
    end else if (wr_ctl) begin
      cont_r <= I_PWDATA[`ADCC_BIT_CONT];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      chan_r <= `ADCC_CH_RESET;
    end else if (wr_ctl) begin
      chan_r <= I_PWDATA[`ADCC_CH_LSB +: `ADCC_CH_W];
    end
  end

  // Changing these mid-conversion corrupts it; software must wait
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      div_sel_r <= `ADCC_DIV_RESET;
    end else if (wr_clk) begin
      div_sel_r <= I_PWDATA[`ADCC_DIV_LSB +: `ADCC_DIV_W];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      src_bus_r <= 1'b0;
    end else if (wr_clk) begin
      src_bus_r <= I_PWDATA[`ADCC_BIT_SRC];
    end
  end

  // Each completion overwrites, read or not
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      result_r <= 8'h00;
    end else if (conv_done) begin
      result_r <= I_CORE_RESULT;
    end
  end

  // Done flag is read-only; completion wins over a same-cycle clear
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      done_flag_r <= 1'b0;
    end else if (conv_done && !irq_en_r) begin
      done_flag_r <= 1'b1;
    end else if (wr_ctl || rd_res) begin
      done_flag_r <= 1'b0;
    end
  end

  // Pending conversion interrupt
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      conv_irq_r <= 1'b0;
    end else if (conv_done && irq_en_r) begin
      conv_irq_r <= 1'b1;
    end else if (wr_ctl || rd_res) begin
      conv_irq_r <= 1'b0;
    end
  end
  // Flag set while enabled would route to a missing DMA engine
  assign O_CPU_IRQ = conv_irq_r && irq_en_r && !done_flag_r;
  assign O_DMA_REQ = conv_irq_r && irq_en_r && done_flag_r;

  // Unread tracking feeds the overrun event
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      unread_r <= 1'b0;
    end else if (conv_done) begin
      unread_r <= 1'b1;
    end else if (rd_res) begin
      unread_r <= 1'b0;
    end
  end

  assign ev_set[`ADCC_EV_DONE] = conv_done;
  assign ev_set[`ADCC_EV_OVERRUN] = conv_done && unread_r && !rd_res;

  // Sticky events; a read clears, a new event in that cycle survives
  for (genvar gi = 0; gi < `ADCC_EV_W; gi++) begin : g_ev
    always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
        ev_status_r[gi] <= 1'b0;
      end else if (ev_set[gi]) begin
        ev_status_r[gi] <= 1'b1;
      end else if (rd_evs) begin
        ev_status_r[gi] <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      ev_mask_r <= '0;
    end else if (wr_msk) begin
      ev_mask_r <= I_PWDATA[`ADCC_EV_W-1:0];
    end
  end
  assign O_IRQ = |(ev_status_r & ev_mask_r);

  // Read data registered in the setup cycle, valid in the access phase
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_PRDATA <= 32'h0;
    end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      case (I_PADDR)
        `ADCC_OFF_STATUS_CONTROL: begin
          O_PRDATA <= {24'h0, done_flag_r, irq_en_r, cont_r, chan_r};
        end
        `ADCC_OFF_RESULT: begin
          O_PRDATA <= {24'h0, result_r};
        end
        `ADCC_OFF_CLOCK_CONFIG: begin
          O_PRDATA <= {24'h0, div_sel_r, src_bus_r, 4'h0};
        end
        `ADCC_OFF_IRQ_STATUS: begin
          O_PRDATA <= {30'h0, ev_status_r};
        end
        `ADCC_OFF_IRQ_MASK: begin
          O_PRDATA <= {30'h0, ev_mask_r};
        end
        default: begin
          O_PRDATA <= 32'h0;
        end
      endcase
    end
  end
endmodule : adcc_top
`default_nettype wire

// *** sim/adcc_top_asserts.sv ***
`default_nettype none
module adcc_top_asserts (
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic [11:0] I_PADDR,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic I_CORE_DONE,
  input wire logic O_CORE_START,
  input wire logic [4:0] O_CORE_CHANNEL,
  input wire logic O_CORE_POWER_ON,
  input wire logic [2:0] O_CORE_INPUT,
  input wire logic O_CONV_CLK_EN,
  input wire logic O_CPU_IRQ,
  input wire logic O_DMA_REQ
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  logic acc;
  assign acc = I_PSEL && I_PENABLE && !I_CORE_DONE;
  a_start_on_tick: assert property (O_CORE_START |-> O_CONV_CLK_EN && O_CORE_POWER_ON) else $error("bad start");
  a_start_one_cycle: assert property (O_CORE_START |=> !O_CORE_START) else $error("long start");
  a_power_off_code: assert property (O_CORE_POWER_ON == (O_CORE_CHANNEL != 5'h1f)) else $error("power");
  a_input_decode: assert property (O_CORE_INPUT == (O_CORE_CHANNEL <= 5'h03 ? 3'd0 : O_CORE_CHANNEL == 5'h1d ? 3'd1 :
    O_CORE_CHANNEL == 5'h1e ? 3'd2 : O_CORE_CHANNEL == 5'h1f ? 3'd4 : 3'd3)) else $error("decode");
  a_irq_read_drop: assert property (acc && !I_PWRITE && I_PADDR == 12'h040 |=> !O_CPU_IRQ && !O_DMA_REQ)
    else $error("irq kept on read");
  a_irq_write_drop: assert property (acc && I_PWRITE && I_PADDR == 12'h03c |=> !O_CPU_IRQ && !O_DMA_REQ)
    else $error("irq kept on write");
  a_irq_has_cause: assert property ($rose(O_CPU_IRQ) |-> $past(I_CORE_DONE)) else $error("irq no done");
  a_reset_state: assert property ($fell(I_SRST) |-> O_CORE_CHANNEL == 5'h1f && !O_CPU_IRQ && !O_DMA_REQ)
    else $error("reset state");
endmodule : adcc_top_asserts
bind adcc_top adcc_top_asserts u_chk (.I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST), .I_PADDR(I_PADDR), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_CORE_DONE(I_CORE_DONE), .O_CORE_START(O_CORE_START),
  .O_CORE_CHANNEL(O_CORE_CHANNEL), .O_CORE_POWER_ON(O_CORE_POWER_ON), .O_CORE_INPUT(O_CORE_INPUT),
  .O_CONV_CLK_EN(O_CONV_CLK_EN), .O_CPU_IRQ(O_CPU_IRQ), .O_DMA_REQ(O_DMA_REQ));
`default_nettype wire

// *** sim/adcc_top_test.sv ***
`default_nettype none
module adcc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, pen, pwr, osc, done, rdy, err, start, pon, cken, irq, cirq, dma;
  logic [11:0] addr;
  logic [31:0] wd, prd;
  logic [7:0] res, rd;
  logic [4:0] ch;
  logic [2:0] inp;
  int fails, compares, n;
  logic [7:0] cs [5] = '{8'h02, 8'h1d, 8'h1e, 8'h04, 8'h1f};
  adcc_top uut (.I_REF_CLK(clk), .I_SRST(rst), .I_PADDR(addr), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PWDATA(wd), .I_PSTRB(4'hf), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err), .I_OSC_CLK_EN(osc),
    .I_CORE_DONE(done), .I_CORE_RESULT(res), .O_CORE_START(start), .O_CORE_CHANNEL(ch), .O_CORE_POWER_ON(pon),
    .O_CORE_INPUT(inp), .O_CONV_CLK_EN(cken), .O_IRQ(irq), .O_CPU_IRQ(cirq), .O_DMA_REQ(dma));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Oscillator enable at half the bus rate
  always @(posedge clk) osc <= ~osc;
  task print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task tick(input logic want, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        fails++;
        print_verdict();
      end
    end while (want !== 1'b1 && ((lim == 100 && start !== 1'b1) || (lim == 40 && cken !== 1'b1)));
  endtask : tick
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    addr <= a;
    wd <= {24'h0, d};
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        fails++;
        print_verdict();
      end
    end while (rdy !== 1'b1);
    rd = prd[7:0];
    psel <= 0;
    pen <= 0;
  endtask : apb
  task rchk(input logic [11:0] a, input logic [7:0] e);
    apb(0, a, 8'h0);
    chk(rd, e);
  endtask : rchk
  // Core answers 16 cycles after its start pulse
  task conv(input logic [7:0] r);
    tick(1'b0, 100);
    repeat (16) @(posedge clk);
    done <= 1;
    res <= r;
    @(posedge clk);
    done <= 0;
  endtask : conv
  initial begin
    fails = 0;
    compares = 0;
    {psel, pen, pwr, osc, done, addr, wd, res} = '0;
    rst = 1;
    repeat (12) @(posedge clk);
    rst <= 0;
    rchk(12'h03c, 8'h1f);
    rchk(12'h044, 8'h00);
    apb(0, 12'h050, 8'h0);
    chk({7'h0, err}, 8'h01);
    $display("reset test done");
    apb(1, 12'h04c, 8'h01);
    apb(1, 12'h03c, 8'h02);
    conv(8'ha5);
    @(posedge clk);
    chk({7'h0, irq}, 8'h01);
    rchk(12'h03c, 8'h82);
    rchk(12'h040, 8'ha5);
    rchk(12'h03c, 8'h02);
    rchk(12'h048, 8'h01);
    @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    n = 0;
    repeat (60) @(posedge clk) if (start === 1'b1) n++;
    chk(n[7:0], 8'h00);
    $display("single test done");
    apb(1, 12'h03c, 8'h41);
    conv(8'h3c);
    @(posedge clk);
    chk({6'h0, dma, cirq}, 8'h01);
    rchk(12'h040, 8'h3c);
    @(posedge clk);
    chk({7'h0, cirq}, 8'h00);
    apb(1, 12'h03c, 8'h41);
    conv(8'h11);
    apb(1, 12'h03c, 8'h41);
    @(posedge clk);
    chk({7'h0, cirq}, 8'h00);
    $display("interrupt test done");
    apb(1, 12'h03c, 8'h3d);
    conv(8'h01);
    conv(8'h02);
    rchk(12'h040, 8'h02);
    $display("continuous test done");
    for (int i = 0; i < 5; i++) begin
      apb(1, 12'h03c, cs[i]);
      @(posedge clk);
      chk({5'h0, inp}, (i == 4) ? 8'h04 : i[7:0]);
      chk({7'h0, pon}, {7'h0, i != 4});
    end
    $display("channel test done");
    for (int i = 0; i < 6; i++) begin
      apb(1, 12'h044, (i == 5) ? 8'h20 : {i[2:0], 5'h10});
      tick(1'b0, 40);
      tick(1'b0, 40);
      chk(n[7:0], (i == 5) ? 8'h04 : 8'h01 << i);
    end
    $display("prescaler test done");
    print_verdict();
  end
endmodule : adcc_top_test
`default_nettype wire
